// [logic/cgc_pkg.sv]
// package for the can global control, status and interrupt block
// assumes a 32-bit axi4-lite register bus with word-aligned registers
package cgc_pkg;
	// register byte addresses
	localparam logic [7:0] ADDR_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h08;
	localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h0C;
	localparam logic [7:0] ADDR_IN_USE_LOW = 8'h10;
	localparam logic [7:0] ADDR_IN_USE_HIGH = 8'h14;
	localparam logic [7:0] ADDR_TIMER = 8'h18;
	localparam logic [7:0] ADDR_TTC_TIMER = 8'h1C;
	// control bits
	localparam int CTL_ABORT = 7;
	localparam int CTL_OVLD_REQ = 6;
	localparam int CTL_TTC = 5;
	localparam int CTL_SYNC = 4;
	localparam int CTL_ONLY_MODE_A = 3;
	localparam int CTL_TEST = 2;
	localparam int CTL_ENA = 1;
	localparam int CTL_SOFTWARE_RESET_REQUEST = 0;
	// status bits
	localparam int ST_OVERLOAD_FRAME_ACTIVE = 6;
	localparam int ST_TRANSMITTER_BUSY_FLAG = 4;
	localparam int ST_RECEIVER_BUSY_FLAG = 3;
	localparam int ST_ENABLED_STATE_FLAG = 2;
	localparam int ST_BUS_OFF_STATE = 1;
	localparam int ST_ERROR_PASSIVE_STATE = 0;
	// interrupt flag bits
	localparam int IT_SUMMARY = 7;
	localparam int IT_BUS_OFF_STATE = 6;
	localparam int IT_TIMER_OVERRUN_FLAG = 5;
	localparam int IT_FRAME_BUFFER_COMPLETE_FLAG = 4;
	localparam int IT_GENERAL_STUFF_ERROR = 3;
	localparam int IT_GENERAL_CRC_ERROR = 2;
	localparam int IT_GENERAL_FORM_ERROR = 1;
	localparam int IT_GENERAL_ACK_ERROR = 0;
	// interrupt enable bits
	localparam int IE_MASTER = 7;
	localparam int IE_BUS_OFF_STATE = 6;
	localparam int IE_RX = 5;
	localparam int IE_TX = 4;
	localparam int IE_ERR = 3;
	localparam int IE_BX = 2;
	localparam int IE_ERG = 1;
	localparam int IE_OVRT = 0;
	// reset values and other constants
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;
	localparam int NUM_OBJECTS = 15;
	localparam logic [3:0] IDLE_BITS_NEEDED = 4'hB;
	localparam logic [15:0] TIMER_MAX = 16'hFFFF;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		CGC_STANDBY = 2'b00,
		CGC_WAIT_IDLE = 2'b01,
		CGC_ENABLED = 2'b10,
		CGC_DRAINING = 2'b11
	} cgc_mode_e;
endpackage

// [logic/cgc_top.sv]
// can global control, status and interrupt registers with axi4-lite slave
// assumes the can protocol engine drives the event and state inputs on aclk
//
// Summary of operation
// - ttc capture at sof or eof per select
// - enable command delayed; enabled flag shows truth
// - standby waits for transmission end, then freezes
// - standby: recessive tx, receiver off, registers open
// - enable only after 11 recessive bits
// - software reset acts like hardware reset except on the bus side, self-clears
// - overload flag follows own overload frame, no irq
// - transmitter busy flag follows sending, no irq
// - receiver busy flag follows receiving, no irq
// - bus-off, error-passive status; only bus-off interrupts
// - summary bit ors all sources but overrun
// - bus-off flag sets on passive to bus-off
// - writing one clears flag, zero keeps it
// - overrun sets on timer wrap, handler entry clears
// - buffer-complete clear needs all configs rewritten
// - general stuff error flag on stuff violation
// - general crc error flag on crc mismatch
// - general form and ack error flags
// - master enable plus separate per-source enables
// - fifteen in-use bits set/clear per object events
// - abort clears in-use bits, frame ends normally
// - timer starts from zero when enabled
`timescale 1ns/1ps
`default_nettype none

module cgc_top (
	// clock, reset, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	// axi4-lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// protocol engine state
	input wire logic bus_recessive_bit,
	input wire logic tx_frame_active,
	input wire logic rx_frame_active,
	input wire logic overload_frame_active,
	input wire logic error_passive_state,
	input wire logic bus_off_state,
	input wire logic sof_pulse,
	input wire logic eof_last_bit_pulse,
	input wire logic timer_tick,
	// protocol engine events
	input wire logic stuff_error_evt,
	input wire logic crc_error_evt,
	input wire logic form_error_evt,
	input wire logic ack_error_evt,
	input wire logic frame_buffer_done_evt,
	input wire logic buffer_configs_rewritten,
	input wire logic overrun_handler_entry,
	input wire logic object_rx_irq,
	input wire logic object_tx_irq,
	input wire logic object_err_irq,
	// message object bookkeeping
	input wire logic [14:0] object_enable_evt,
	input wire logic [14:0] object_done_evt,
	input wire logic [14:0] object_disable_evt,
	// controls to the protocol engine
	output logic can_tx,
	output logic receiver_enable,
	output logic channel_frozen,
	output logic abort_request,
	output logic overload_request,
	output logic only_mode_a,
	output logic time_trigger_mode,
	output logic factory_test_mode,
	output logic controller_reset,
	output logic [15:0] can_timer,
	output logic irq
);
	// ****************************************
	// reset and control
	// ****************************************
	logic [7:0] control_q;
	logic [7:0] enables_q;
	logic [5:0] flags_q;
	logic [14:0] in_use_q;
	logic [15:0] timer_q;
	logic [15:0] ttc_q;
	logic [3:0] idle_cnt_q;
	logic bus_off_seen_q;
	logic software_reset_request_q;
	cgc_pkg::cgc_mode_e mode_q;
	cgc_pkg::cgc_mode_e mode_d;

	wire rst = !aresetn || software_reset_request_q;
	assign controller_reset = software_reset_request_q;

	// ****************************************
	// axi4-lite slave
	// ****************************************
	logic aw_held_q;
	logic w_held_q;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic [31:0] rdata_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [1:0] rresp_q;

	wire aw_take = s_axi_awvalid && !aw_held_q && !bvalid_q;
	wire w_take = s_axi_wvalid && !w_held_q && !bvalid_q;
	wire have_aw = aw_held_q || aw_take;
	wire have_w = w_held_q || w_take;
	wire [7:0] wr_addr = aw_held_q ? aw_addr_q : s_axi_awaddr;
	wire [31:0] wr_data = w_held_q ? w_data_q : s_axi_wdata;
	wire [3:0] wr_strb = w_held_q ? w_strb_q : s_axi_wstrb;
	wire wr_fire = clk_en && have_aw && have_w && !bvalid_q;
	wire wr_lane0 = wr_fire && wr_strb[0];
	wire wr_ctl = wr_lane0 && (wr_addr == cgc_pkg::ADDR_CONTROL);
	wire wr_flags = wr_lane0 && (wr_addr == cgc_pkg::ADDR_IRQ_FLAGS);
	wire wr_ie = wr_lane0 && (wr_addr == cgc_pkg::ADDR_IRQ_ENABLE);
	wire wr_mapped = (wr_addr == cgc_pkg::ADDR_CONTROL) || (wr_addr == cgc_pkg::ADDR_STATUS)
		|| (wr_addr == cgc_pkg::ADDR_IRQ_FLAGS) || (wr_addr == cgc_pkg::ADDR_IRQ_ENABLE)
		|| (wr_addr == cgc_pkg::ADDR_IN_USE_LOW) || (wr_addr == cgc_pkg::ADDR_IN_USE_HIGH)
		|| (wr_addr == cgc_pkg::ADDR_TIMER) || (wr_addr == cgc_pkg::ADDR_TTC_TIMER);
	wire rd_fire = clk_en && s_axi_arvalid && !rvalid_q;

	assign s_axi_awready = !aw_held_q && !bvalid_q;
	assign s_axi_wready = !w_held_q && !bvalid_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;

	// bus side survives the software reset so the answer is not lost
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= 2'h0;
		end else if (clk_en) begin
			if (wr_fire) begin
				aw_held_q <= 1'b0;
				w_held_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_mapped ? cgc_pkg::RESP_OKAY : cgc_pkg::RESP_SLVERR;
			end else begin
				if (aw_take) begin
					aw_held_q <= 1'b1;
					aw_addr_q <= s_axi_awaddr;
				end
				if (w_take) begin
					w_held_q <= 1'b1;
					w_data_q <= s_axi_wdata;
					w_strb_q <= s_axi_wstrb;
				end
				if (bvalid_q && s_axi_bready) begin
					bvalid_q <= 1'b0;
				end
			end
		end
	end

	// ****************************************
	// status and read mux
	// ****************************************
	wire enabled_state_flag = (mode_q == cgc_pkg::CGC_ENABLED)
		|| (mode_q == cgc_pkg::CGC_DRAINING);
	logic ack_flag_q;
	// general error group: stuff, crc, form and ack, never the buffer flag
	wire gen_err = |flags_q[2:0] || ack_flag_q;
	wire summary_interrupt = (flags_q[5] && enables_q[cgc_pkg::IE_BUS_OFF_STATE])
		|| (flags_q[3] && enables_q[cgc_pkg::IE_BX])
		|| (gen_err && enables_q[cgc_pkg::IE_ERG])
		|| (object_rx_irq && enables_q[cgc_pkg::IE_RX])
		|| (object_tx_irq && enables_q[cgc_pkg::IE_TX])
		|| (object_err_irq && enables_q[cgc_pkg::IE_ERR]);
	// flags_q: 5 bus-off, 4 overrun, 3 buffer, 2 stuff, 1 crc... remapped below
	wire [7:0] flags_view = {summary_interrupt, flags_q[5], flags_q[4], flags_q[3],
		flags_q[2], flags_q[1], flags_q[0], ack_flag_q};
	wire [7:0] status_view = {1'b0, overload_frame_active, 1'b0, tx_frame_active,
		rx_frame_active, enabled_state_flag, bus_off_state, error_passive_state};

	logic [31:0] rd_mux;
	logic rd_ok;
	always_comb begin
		rd_mux = 32'h00000000;
		rd_ok = 1'b1;
		case (s_axi_araddr)
			cgc_pkg::ADDR_CONTROL: rd_mux = {24'h000000, control_q};
			cgc_pkg::ADDR_STATUS: rd_mux = {24'h000000, status_view};
			cgc_pkg::ADDR_IRQ_FLAGS: rd_mux = {24'h000000, flags_view};
			cgc_pkg::ADDR_IRQ_ENABLE: rd_mux = {24'h000000, enables_q};
			cgc_pkg::ADDR_IN_USE_LOW: rd_mux = {24'h000000, in_use_q[7:0]};
			cgc_pkg::ADDR_IN_USE_HIGH: rd_mux = {25'h0000000, in_use_q[14:8]};
			cgc_pkg::ADDR_TIMER: rd_mux = {16'h0000, timer_q};
			cgc_pkg::ADDR_TTC_TIMER: rd_mux = {16'h0000, ttc_q};
			default: rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= 2'h0;
		end else if (clk_en) begin
			if (rd_fire) begin
				rvalid_q <= 1'b1;
				rdata_q <= rd_mux;
				rresp_q <= rd_ok ? cgc_pkg::RESP_OKAY : cgc_pkg::RESP_SLVERR;
			end else if (rvalid_q && s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	// ****************************************
	// control register and software reset
	// ****************************************
	// self-clearing reset pulse, one cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			software_reset_request_q <= 1'b0;
		end else if (clk_en) begin
			software_reset_request_q <= wr_ctl && wr_data[cgc_pkg::CTL_SOFTWARE_RESET_REQUEST];
		end
	end

	always_ff @(posedge aclk) begin
		if (rst) begin
			control_q <= cgc_pkg::CONTROL_RESET;
			enables_q <= cgc_pkg::IRQ_ENABLE_RESET;
		end else if (clk_en) begin
			if (wr_ctl) begin
				control_q <= {wr_data[7:1], 1'b0};
			end
			if (wr_ie) begin
				enables_q <= wr_data[7:0];
			end
		end
	end

	assign abort_request = control_q[cgc_pkg::CTL_ABORT];
	assign overload_request = control_q[cgc_pkg::CTL_OVLD_REQ];
	assign time_trigger_mode = control_q[cgc_pkg::CTL_TTC];
	assign only_mode_a = control_q[cgc_pkg::CTL_ONLY_MODE_A];
	// test bit passed through; software must leave it at zero
	assign factory_test_mode = control_q[cgc_pkg::CTL_TEST];

	// ****************************************
	// enable / standby mode
	// ****************************************
	wire ena_cmd = control_q[cgc_pkg::CTL_ENA];
	wire idle_done = idle_cnt_q == cgc_pkg::IDLE_BITS_NEEDED;

	always_comb begin
		mode_d = mode_q;
		case (mode_q)
			cgc_pkg::CGC_STANDBY: begin
				if (ena_cmd) mode_d = cgc_pkg::CGC_WAIT_IDLE;
			end
			cgc_pkg::CGC_WAIT_IDLE: begin
				if (!ena_cmd) mode_d = cgc_pkg::CGC_STANDBY;
				else if (idle_done) mode_d = cgc_pkg::CGC_ENABLED;
			end
			cgc_pkg::CGC_ENABLED: begin
				if (!ena_cmd) mode_d = cgc_pkg::CGC_DRAINING;
			end
			cgc_pkg::CGC_DRAINING: begin
				if (!tx_frame_active) mode_d = cgc_pkg::CGC_STANDBY;
			end
			default: mode_d = cgc_pkg::CGC_STANDBY;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (rst) begin
			mode_q <= cgc_pkg::CGC_STANDBY;
			idle_cnt_q <= 4'h0;
		end else if (clk_en) begin
			mode_q <= mode_d;
			if (mode_q != cgc_pkg::CGC_WAIT_IDLE || !bus_recessive_bit) begin
				idle_cnt_q <= 4'h0;
			end else if (timer_tick && !idle_done) begin
				idle_cnt_q <= idle_cnt_q + 4'h1;
			end
		end
	end
	assign can_tx = 1'b1;
	assign receiver_enable = enabled_state_flag;
	assign channel_frozen = mode_q == cgc_pkg::CGC_STANDBY;

	// ****************************************
	// timers
	// ****************************************
	always_ff @(posedge aclk) begin
		if (rst) begin
			timer_q <= 16'h0000;
			ttc_q <= 16'h0000;
		end else if (clk_en) begin
			// timer runs from zero while enabled
			if (!enabled_state_flag) begin
				timer_q <= 16'h0000;
			end else if (timer_tick) begin
				timer_q <= timer_q + 16'h0001;
			end
			// capture point chosen by select bit
			if (time_trigger_mode && (control_q[cgc_pkg::CTL_SYNC] ?
				eof_last_bit_pulse : sof_pulse)) begin
				ttc_q <= timer_q;
			end
		end
	end
	assign can_timer = timer_q;
	wire timer_wrap = enabled_state_flag && timer_tick && (timer_q == cgc_pkg::TIMER_MAX);

	// ****************************************
	// interrupt flags and in-use bits
	// ****************************************
	wire [7:0] clr = wr_flags ? wr_data[7:0] : 8'h00;
	wire bus_off_state_entry = bus_off_state && !bus_off_seen_q;

	always_ff @(posedge aclk) begin
		if (rst) begin
			flags_q <= 6'h00;
			ack_flag_q <= 1'b0;
			bus_off_seen_q <= 1'b0;
		end else if (clk_en) begin
			bus_off_seen_q <= bus_off_state;
			flags_q[5] <= bus_off_state_entry || (flags_q[5] && !clr[cgc_pkg::IT_BUS_OFF_STATE]);
			flags_q[4] <= timer_wrap || (flags_q[4] && !clr[cgc_pkg::IT_TIMER_OVERRUN_FLAG]
				&& !overrun_handler_entry);
			flags_q[3] <= frame_buffer_done_evt || (flags_q[3]
				&& !(clr[cgc_pkg::IT_FRAME_BUFFER_COMPLETE_FLAG] && buffer_configs_rewritten));
			flags_q[2] <= stuff_error_evt || (flags_q[2] && !clr[cgc_pkg::IT_GENERAL_STUFF_ERROR]);
			flags_q[1] <= crc_error_evt || (flags_q[1] && !clr[cgc_pkg::IT_GENERAL_CRC_ERROR]);
			flags_q[0] <= form_error_evt || (flags_q[0] && !clr[cgc_pkg::IT_GENERAL_FORM_ERROR]);
			ack_flag_q <= ack_error_evt || (ack_flag_q && !clr[cgc_pkg::IT_GENERAL_ACK_ERROR]);
		end
	end

	wire in_use_wipe = abort_request || channel_frozen;
	always_ff @(posedge aclk) begin
		if (rst) begin
			in_use_q <= 15'h0000;
		end else if (clk_en) begin
			if (in_use_wipe) begin
				in_use_q <= 15'h0000;
			end else begin
				in_use_q <= (in_use_q | object_enable_evt) & ~(object_done_evt | object_disable_evt);
			end
		end
	end

	assign irq = (summary_interrupt && enables_q[cgc_pkg::IE_MASTER])
		|| (flags_q[4] && enables_q[cgc_pkg::IE_OVRT]);
endmodule

`default_nettype wire

// [testbench/cgc_asserts.sv]
// concurrent checks on the ports of the can global control block
// assumes one clock domain, aresetn synchronous and active low
`timescale 1ns/1ps
`default_nettype none
module cgc_asserts (
	// clock, reset
	input wire logic aclk,
	input wire logic aresetn,
	// register bus
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// engine side
	input wire logic bus_recessive_bit,
	input wire logic timer_tick,
	input wire logic tx_frame_active,
	input wire logic can_tx,
	input wire logic receiver_enable,
	input wire logic channel_frozen,
	input wire logic controller_reset,
	input wire logic irq,
	input wire logic [15:0] can_timer
);
	// ****
	// helpers
	// ****
	logic [3:0] run_q;
	logic wr_go;
	assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	// counts only at ticks, so it never lags the design's own idle count
	always_ff @(posedge aclk) begin
		if (!aresetn || (timer_tick && !bus_recessive_bit)) begin
			run_q <= 4'h0;
		end else if (timer_tick && run_q != 4'hF) begin
			run_q <= run_q + 4'h1;
		end
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ****
	// assertions
	// ****
	tx_recessive_a: assert property (can_tx)
		else $error("transmit line left recessive level");
	frozen_rx_off_a: assert property (channel_frozen |-> !receiver_enable)
		else $error("receiver on while frozen");
	enable_idle_a: assert property ($rose(receiver_enable) |-> run_q >= 4'hB)
		else $error("enabled before eleven recessive bits");
	standby_wait_a: assert property ($rose(channel_frozen) |-> !$past(tx_frame_active))
		else $error("frozen during a transmission");
	software_reset_request_pulse_a: assert property (wr_go && s_axi_awaddr == cgc_pkg::ADDR_CONTROL
		&& s_axi_wdata[0] |=> controller_reset ##1 !controller_reset)
		else $error("software reset pulse wrong");
	reset_clear_a: assert property (controller_reset |=> !receiver_enable && !irq
		&& can_timer == 16'h0000)
		else $error("software reset left state behind");
	timer_start_a: assert property ($rose(receiver_enable) |-> can_timer <= 16'h0001)
		else $error("timer not restarted at enable");
	wr_answer_a: assert property (wr_go |=> s_axi_bvalid)
		else $error("write response late");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata))
		else $error("read data not held");
	cover property ($rose(receiver_enable));
	cover property ($rose(channel_frozen));
	cover property (controller_reset);
endmodule
bind cgc_top cgc_asserts u_cgc_asserts (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
	.bus_recessive_bit, .timer_tick, .tx_frame_active, .can_tx, .receiver_enable,
	.channel_frozen, .controller_reset, .irq, .can_timer);
`default_nettype wire

// [testbench/cgc_bus_node.sv]
// other nodes on the can bus, as the protocol engine reports them
// assumes one clock; a frame starts on a bench request while idle
`timescale 1ns/1ps
`default_nettype none
module cgc_bus_node #(
	parameter int DIV = 3,
	parameter int BITS = 24
) (
	// clock, reset
	input wire logic aclk,
	input wire logic aresetn,
	// bench requests
	input wire logic frame_go,
	input wire logic own_frame,
	// engine view
	output logic bus_recessive_bit,
	output logic timer_tick,
	output logic sof_pulse,
	output logic eof_last_bit_pulse,
	output logic rx_frame_active,
	output logic tx_frame_active
);
	// ****
	// frame sequencer
	// ****
	int div_q;
	int bit_q;
	logic act_q;
	logic tick;
	assign tick = (div_q == DIV - 1);
	assign rx_frame_active = act_q;
	assign tx_frame_active = act_q && own_frame;
	// bits alternate in a frame, so no recessive run survives it
	assign bus_recessive_bit = !act_q || bit_q[0];
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_q <= 0;
			bit_q <= 0;
			act_q <= 1'h0;
			timer_tick <= 1'h0;
			sof_pulse <= 1'h0;
			eof_last_bit_pulse <= 1'h0;
		end else begin
			div_q <= tick ? 0 : div_q + 1;
			timer_tick <= tick;
			sof_pulse <= frame_go && !act_q;
			eof_last_bit_pulse <= tick && act_q && bit_q == BITS - 1;
			if (frame_go && !act_q) begin
				act_q <= 1'h1;
				bit_q <= 0;
			end else if (tick && act_q) begin
				bit_q <= bit_q + 1;
				act_q <= bit_q != BITS - 1;
			end
		end
	end
endmodule
`default_nettype wire

// [testbench/can_global_control_status_irq_bench.sv]
// self-checking bench for the can global control, status and interrupt block
// assumes cgc_top, cgc_bus_node and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module can_global_control_status_irq_bench;
	// ****
	// signals
	// ****
	localparam logic [7:0] A_CTL = cgc_pkg::ADDR_CONTROL;
	localparam logic [7:0] A_ST = cgc_pkg::ADDR_STATUS;
	localparam logic [7:0] A_FL = cgc_pkg::ADDR_IRQ_FLAGS;
	localparam logic [7:0] A_IE = cgc_pkg::ADDR_IRQ_ENABLE;
	localparam logic [31:0] ENA = 32'h1 << cgc_pkg::CTL_ENA;
	localparam logic [31:0] ENABLED_STATE_FLAG = 32'h1 << cgc_pkg::ST_ENABLED_STATE_FLAG;
	typedef struct packed {
		logic [31:0] m;
		logic [31:0] d;
		logic [1:0] r;
	} cgc_exp_s;
	cgc_exp_s rq[$];
	cgc_exp_s e;
	logic [1:0] bq[$];
	int errors = 0;
	int n_tests = 0;
	int cyc = 0;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, can_tx, receiver_enable, irq, node_tick, sof_pulse;
	logic eof_last_bit_pulse, bus_recessive_bit, rx_frame_active, tx_frame_active;
	logic overload_frame_active = 0, error_passive_state = 0, bus_off_state = 0;
	logic buffer_configs_rewritten = 0, overrun_handler_entry = 0, object_rx_irq = 0;
	logic fast = 0, frame_go = 0, own_frame = 0, clk_en = 1;
	logic [4:0] ev = 5'h00;
	logic [14:0] object_enable_evt = 0, object_done_evt = 0, object_disable_evt = 0;
	wire logic timer_tick = fast || node_tick;

	cgc_top u_cgc_top (.aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bus_recessive_bit,
		.tx_frame_active, .rx_frame_active, .overload_frame_active, .error_passive_state,
		.bus_off_state, .sof_pulse, .eof_last_bit_pulse, .timer_tick, .stuff_error_evt(ev[3]),
		.crc_error_evt(ev[2]), .form_error_evt(ev[1]), .ack_error_evt(ev[0]),
		.frame_buffer_done_evt(ev[4]), .buffer_configs_rewritten, .overrun_handler_entry,
		.object_rx_irq, .object_tx_irq(1'h0), .object_err_irq(1'h0), .object_enable_evt,
		.object_done_evt, .object_disable_evt, .can_tx, .receiver_enable, .channel_frozen(),
		.abort_request(), .overload_request(), .only_mode_a(), .time_trigger_mode(),
		.factory_test_mode(), .controller_reset(), .can_timer(), .irq);
	cgc_bus_node u_cgc_bus_node (.aclk, .aresetn, .frame_go, .own_frame, .bus_recessive_bit,
		.timer_tick(node_tick), .sof_pulse, .eof_last_bit_pulse, .rx_frame_active,
		.tx_frame_active);

	always #20 aclk = ~aclk;
	// ****
	// checking
	// ****
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test;
		$display("errors %0d tests %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// hang guard sized for the long timer wrap
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 80000) begin
			errors++;
			stop_test();
		end
		if (s_axi_rvalid && s_axi_rready && rq.size() > 0) begin
			e = rq.pop_front();
			check(s_axi_rdata & e.m, e.d);
			check({30'h0, s_axi_rresp}, {30'h0, e.r});
		end
		if (s_axi_bvalid && s_axi_bready && bq.size() > 0)
			check({30'h0, s_axi_bresp}, {30'h0, bq.pop_front()});
	end
	// ****
	// bus master
	// ****
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
		bq.push_back(r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
		repeat ($urandom_range(2)) @(posedge aclk);
		s_axi_bready <= 1'h1;
		do @(posedge aclk); while (!s_axi_bvalid);
		s_axi_bready <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m = 32'hFF,
		input logic [1:0] r = 2'h0);
		rq.push_back('{m, d, r});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		repeat ($urandom_range(2)) @(posedge aclk);
		s_axi_rready <= 1'h1;
		do @(posedge aclk); while (!s_axi_rvalid);
		s_axi_rready <= 1'h0;
	endtask
	task automatic pulse(input int i);
		ev[i] <= 1'h1;
		@(posedge aclk);
		ev <= 5'h00;
	endtask
	// ****
	// scenarios
	// ****
	initial begin
		logic [14:0] obj;
		void'($urandom(12));
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		for (int i = 0; i < 6; i++) rd(8'(4 * i), 32'h0);
		rd(8'h20, 32'h0, 32'h0, cgc_pkg::RESP_SLVERR);
		wr(8'h20, 32'hFF, cgc_pkg::RESP_SLVERR);
		// test bit left clear in every control write
		wr(A_CTL, ENA);
		rd(A_ST, 32'h0);
		repeat (40) @(posedge aclk);
		rd(A_ST, ENABLED_STATE_FLAG);
		error_passive_state <= 1'h1;
		@(posedge aclk);
		bus_off_state <= 1'h1;
		overload_frame_active <= 1'h1;
		rd(A_ST, ENABLED_STATE_FLAG | 32'h43);
		rd(A_FL, 32'h40);
		wr(A_FL, 32'h40);
		rd(A_FL, 32'h00);
		{error_passive_state, bus_off_state, overload_frame_active} <= 3'h0;
		wr(A_IE, 32'h82);
		for (int i = 0; i < 4; i++) begin
			pulse(i);
			rd(A_FL, (32'h1 << i) | 32'h80);
			check({31'h0, irq}, 32'h1);
			wr(A_FL, 32'h0);
			rd(A_FL, (32'h1 << i) | 32'h80);
			wr(A_FL, 32'h1 << i);
			rd(A_FL, 32'h0);
		end
		// an event while clk_en is low is lost
		clk_en <= 1'h0;
		pulse(1);
		clk_en <= 1'h1;
		rd(A_FL, 32'h0);
		wr(A_IE, 32'h02);
		pulse(0);
		rd(A_FL, 32'h81);
		check({31'h0, irq}, 32'h0);
		wr(A_FL, 32'h01);
		object_rx_irq <= 1'h1;
		wr(A_IE, 32'hA4);
		check({31'h0, irq}, 32'h1);
		object_rx_irq <= 1'h0;
		pulse(4);
		wr(A_FL, 32'h10);
		rd(A_FL, 32'h90);
		buffer_configs_rewritten <= 1'h1;
		wr(A_FL, 32'h10);
		rd(A_FL, 32'h00);
		obj = 15'($urandom) | 15'h4001;
		object_enable_evt <= obj;
		@(posedge aclk);
		object_enable_evt <= 15'h0;
		object_done_evt <= 15'h0001;
		object_disable_evt <= 15'h4000;
		@(posedge aclk);
		object_done_evt <= 15'h0;
		object_disable_evt <= 15'h0;
		rd(cgc_pkg::ADDR_IN_USE_LOW, {24'h0, obj[7:1], 1'h0});
		rd(cgc_pkg::ADDR_IN_USE_HIGH, {25'h0, 1'h0, obj[13:8]});
		wr(A_CTL, ENA | (32'h1 << cgc_pkg::CTL_ABORT));
		rd(cgc_pkg::ADDR_IN_USE_LOW, 32'h0);
		wr(A_CTL, ENA);
		own_frame <= 1'h1;
		frame_go <= 1'h1;
		@(posedge aclk);
		frame_go <= 1'h0;
		rd(A_ST, ENABLED_STATE_FLAG | 32'h18);
		wr(A_CTL, 32'h0);
		rd(A_ST, ENABLED_STATE_FLAG | 32'h18);
		while (tx_frame_active) @(posedge aclk);
		repeat (3) @(posedge aclk);
		rd(A_ST, 32'h0);
		rd(cgc_pkg::ADDR_TTC_TIMER, 32'h0, 32'hFFFF);
		check({31'h0, receiver_enable}, 32'h0);
		own_frame <= 1'h0;
		wr(A_CTL, ENA);
		wr(A_IE, 32'h01);
		// enabled first, then one tick a cycle: one wrap, never two
		repeat (40) @(posedge aclk);
		fast <= 1'h1;
		repeat (65540) @(posedge aclk);
		fast <= 1'h0;
		rd(A_FL, 32'h20);
		check({31'h0, irq}, 32'h1);
		overrun_handler_entry <= 1'h1;
		@(posedge aclk);
		overrun_handler_entry <= 1'h0;
		rd(A_FL, 32'h00);
		wr(A_IE, 32'hFF);
		wr(A_CTL, ENA | 32'h1);
		rd(A_CTL, 32'h0);
		rd(A_IE, 32'h0);
		rd(A_ST, 32'h0);
		rd(cgc_pkg::ADDR_TIMER, 32'h0, 32'hFFFF);
		stop_test();
	end
endmodule
`default_nettype wire
